//--- cpu_status_flag_logic.sv
`default_nettype none
// status register of the core: arithmetic flags from the alu, system flags from power management
module cpu_status_flag_logic (
    // clock and power-on reset
    input  wire  logic                  clk,
    input  wire  logic                  nrst,
    // instruction side
    input  wire  logic                  instr_done,
    input  wire  flag_pkg::alu_req_type alu_req,
    // software store into the register
    input  wire  logic                  wr_en,
    input  wire  logic [7:0]            wr_data,
    // power management events
    input  wire  logic                  watchdog_clear_instr,
    input  wire  logic                  sleep_instr,
    input  wire  logic                  wdt_timeout,
    // register read view and last result
    output logic [7:0]                  cpu_status_flags,
    output logic [7:0]                  alu_result
);

    // ----------------------------------------
    // overview
    // ----------------------------------------
    // arithmetic flags follow the alu on each completed instruction
    // a store and an alu update can meet on one edge; the store wins,
    // so that software always reads back what it has just written
    // op_none, or a low instr_done, leaves every arithmetic flag alone
    // the system flags sit in their own module, out of reach of wr_data
    // reset clears the arithmetic bits as well, so that a read before
    // the first instruction shows zero rather than a stale value
    // the flags appear right after the edge that takes the request,
    // and then stand until the next store or affecting instruction
    // back to back requests are fine: each edge is judged on its own
    // limitation: nothing here saves the flags on a call or an interrupt;
    // software that needs them kept has to store them itself

    // ----------------------------------------
    // bit map
    // ----------------------------------------
    // 7 sign compare       read and write
    // 6 chained zero       read and write
    // 5 watchdog time-out  read only
    // 4 power down         read only
    // 3 overflow           read and write
    // 2 zero               read and write
    // 1 half carry         read and write
    // 0 carry              read and write

    // ----------------------------------------
    // state
    // ----------------------------------------
    // arithmetic flags and the last result, kept as one register
    // the result is stored so that the checks can see what the flags describe
    typedef struct packed {
        logic [7:0] res;       // last alu result
        logic       scmp;      // sign compare
        logic       chz;       // chained zero
        logic       ovf;       // overflow
        logic       z;         // zero
        logic       hc;        // half carry
        logic       c;         // carry
    } core_state_type;

    core_state_type        state_ff;
    core_state_type        nxt_state;

    // ----------------------------------------
    // internal nets
    // ----------------------------------------
    // alu answer and the two system flags
    flag_pkg::alu_res_type rsp;
    logic                  to_flag;
    logic                  pd_flag;

    // operation decode
    logic                  is_add;
    logic                  is_addc;
    logic                  is_sub;
    logic                  is_sbc;
    logic                  is_rlc;
    logic                  is_rrc;
    logic                  is_addsub;
    logic                  is_rot;

    // which source owns this edge
    logic                  sw_take;
    logic                  alu_take;

    // flag values offered by the alu path
    logic                  alu_c;
    logic                  alu_hc;
    logic                  alu_ovf;
    logic                  alu_z;
    logic                  alu_scmp;
    logic                  alu_chz;

    // flag values offered by a software store
    logic                  sw_c;
    logic                  sw_hc;
    logic                  sw_ovf;
    logic                  sw_z;
    logic                  sw_scmp;
    logic                  sw_chz;

    // ----------------------------------------
    // datapath and system flags
    // ----------------------------------------
    // purely combinational alu; carry in is the stored carry flag,
    // so the carry chain of addc, sbc and the rotates closes through state_ff
    flag_alu u_alu (
        .req (alu_req),
        .cin (state_ff.c),
        .rsp (rsp)
    );

    // system flags live apart so no software path can reach them
    sys_flags u_sys (
        .clk         (clk),
        .nrst        (nrst),
        .wdt_clear   (watchdog_clear_instr),
        .sleep       (sleep_instr),
        .wdt_timeout (wdt_timeout),
        .to_flag     (to_flag),
        .pd_flag     (pd_flag)
    );

    // ----------------------------------------
    // operation decode
    // ----------------------------------------
    // add forms; addc takes the stored carry in the alu
    assign is_add  = (alu_req.op == flag_pkg::op_add);
    assign is_addc = (alu_req.op == flag_pkg::op_addc);

    // subtract forms; the carry-in choice lives in the alu
    assign is_sub  = (alu_req.op == flag_pkg::op_sub);
    assign is_sbc  = (alu_req.op == flag_pkg::op_sbc);

    // rotate through carry, left and right
    // both use the carry flag as a ninth bit
    assign is_rlc  = (alu_req.op == flag_pkg::op_rlc);
    assign is_rrc  = (alu_req.op == flag_pkg::op_rrc);

    // groups used by the flag selection below
    // logic ops fall in neither group: they touch only zero and sign compare
    assign is_addsub = is_add | is_addc | is_sub | is_sbc;
    assign is_rot    = is_rlc | is_rrc;

    // ----------------------------------------
    // edge ownership
    // ----------------------------------------
    // a software store always takes the edge
    assign sw_take = wr_en;

    // an alu update needs a completed instruction with a real operation,
    // and it loses to a store on the same edge, so that the stored value
    // is what software reads back afterwards
    assign alu_take = instr_done && (alu_req.op != flag_pkg::op_none)
                      && !wr_en;

    // ----------------------------------------
    // alu flag candidates
    // ----------------------------------------
    // carry comes from add, subtract and the two rotates only
    // for subtract the alu adds the inverse, so a carry means no borrow
    assign alu_c = (is_addsub || is_rot) ? rsp.c : state_ff.c;

    // half carry only from add and subtract
    // rotates and logic ops keep the old value
    assign alu_hc = is_addsub ? rsp.hc : state_ff.hc;

    // overflow only from add and subtract; other ops keep the old value
    // carry into bit 7 against carry out of it
    assign alu_ovf = is_addsub ? rsp.ovf : state_ff.ovf;

    // zero follows every operation that reaches the alu
    // logic ops count here too, their result is the a operand
    assign alu_z = rsp.z;

    // sign compare uses the overflow as it stands after this instruction,
    // which for logic ops and rotates is the held overflow
    assign alu_scmp = alu_ovf ^ rsp.res[7];

    // chained zero: copy on plain subtract, and with the old value on
    // subtract with borrow, untouched by everything else
    assign alu_chz = is_sub ? rsp.z
                   : is_sbc ? (state_ff.chz & rsp.z)
                   : state_ff.chz;

    // ----------------------------------------
    // store candidates
    // ----------------------------------------
    // a store writes the six arithmetic bits like any data register
    // bits 5 and 4 of wr_data are never looked at
    assign sw_scmp = wr_data[flag_pkg::SIGN_BIT];
    assign sw_chz  = wr_data[flag_pkg::CHAIN_BIT];

    // low four flags
    assign sw_ovf  = wr_data[flag_pkg::OVF_BIT];
    assign sw_z    = wr_data[flag_pkg::Z_BIT];
    assign sw_hc   = wr_data[flag_pkg::HALF_BIT];
    assign sw_c    = wr_data[flag_pkg::C_BIT];

    // ----------------------------------------
    // flag update
    // ----------------------------------------
    // each flag field: store first, then alu, otherwise hold
    // holding is the default, so a skipped instruction changes nothing
    // one if chain per field keeps the priority visible field by field
    always_comb begin
        nxt_state = state_ff;

        // last result is only refreshed by the alu
        if (alu_take) begin
            nxt_state.res = rsp.res;
        end

        // carry: a stored carry is what the next addc or sbc will use
        if (sw_take) begin
            nxt_state.c = sw_c;
        end else if (alu_take) begin
            nxt_state.c = alu_c;
        end

        // half carry
        if (sw_take) begin
            nxt_state.hc = sw_hc;
        end else if (alu_take) begin
            nxt_state.hc = alu_hc;
        end

        // overflow
        if (sw_take) begin
            nxt_state.ovf = sw_ovf;
        end else if (alu_take) begin
            nxt_state.ovf = alu_ovf;
        end

        // zero
        if (sw_take) begin
            nxt_state.z = sw_z;
        end else if (alu_take) begin
            nxt_state.z = alu_z;
        end

        // sign compare
        if (sw_take) begin
            nxt_state.scmp = sw_scmp;
        end else if (alu_take) begin
            nxt_state.scmp = alu_scmp;
        end

        // chained zero: an sbc chain starts from whatever a store left here
        if (sw_take) begin
            nxt_state.chz = sw_chz;
        end else if (alu_take) begin
            nxt_state.chz = alu_chz;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // asynchronous power-on clear of the whole arithmetic state
    // the reset branch loads constants only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------
    // read view
    // ----------------------------------------
    // bit order is fixed: sign compare at the top, carry at the bottom
    // every bit comes straight from a flop, none is decoded on the way out
    assign cpu_status_flags = {state_ff.scmp,      // bit 7
                               state_ff.chz,       // bit 6
                               to_flag,            // bit 5
                               pd_flag,            // bit 4
                               state_ff.ovf,       // bit 3
                               state_ff.z,         // bit 2
                               state_ff.hc,        // bit 1
                               state_ff.c};        // bit 0

    // last result, for the decoder side
    assign alu_result = state_ff.res;
endmodule : cpu_status_flag_logic
`default_nettype wire

//--- flag_pkg.sv
`default_nettype none
package flag_pkg;
    // ----------------------------------------
    // bit positions
    // ----------------------------------------
    localparam int C_BIT  = 0;
    localparam int HALF_BIT  = 1;
    localparam int Z_BIT     = 2;
    localparam int OVF_BIT   = 3;
    localparam int PD_BIT    = 4;
    localparam int TO_BIT    = 5;
    localparam int CHAIN_BIT = 6;
    localparam int SIGN_BIT  = 7;
    localparam logic [7:0] STATUS_RESET  = 8'h00;
    localparam logic [7:0] SYS_BITS_MASK = 8'h30;

    // ----------------------------------------
    // alu operation classes
    // ----------------------------------------
    typedef enum logic [3:0] {
        op_none  = 4'h0,
        op_add   = 4'h1,
        op_addc  = 4'h2,
        op_sub   = 4'h3,
        op_sbc   = 4'h4,
        op_logic = 4'h5,
        op_rlc   = 4'h6,
        op_rrc   = 4'h7
    } alu_op_type;

    typedef struct packed {
        alu_op_type op;
        logic [7:0] a;
        logic [7:0] b;
    } alu_req_type;

    typedef struct packed {
        logic [7:0] res;
        logic       c;
        logic       hc;
        logic       ovf;
        logic       z;
    } alu_res_type;
endpackage : flag_pkg
`default_nettype wire

//--- flag_alu.sv
`default_nettype none
module flag_alu (
    input  wire flag_pkg::alu_req_type req,
    input  wire logic                  cin,
    output var  flag_pkg::alu_res_type rsp
);
    logic [4:0] lo;
    logic [7:0] lo7;
    logic [8:0] full;
    logic       c7;
    logic [7:0] bb;
    logic       ci;

    // ----------------------------------------
    // arithmetic and flag generation
    // ----------------------------------------
    // subtract is a + ~b + 1 and sbc is a + ~b + cin, so carry out means no borrow
    always_comb begin
        lo   = 5'h00;
        lo7  = 8'h00;
        full = 9'h000;
        c7   = 1'b0;
        bb   = 8'h00;
        ci   = 1'b0;
        rsp  = '0;
        unique case (req.op)
            flag_pkg::op_add, flag_pkg::op_addc, flag_pkg::op_sub, flag_pkg::op_sbc: begin
                bb = (req.op == flag_pkg::op_sub || req.op == flag_pkg::op_sbc) ? ~req.b : req.b;
                ci = (req.op == flag_pkg::op_add) ? 1'b0 : (req.op == flag_pkg::op_sub) ? 1'b1 : cin;
                lo   = {1'b0, req.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
                lo7  = {1'b0, req.a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
                full = {1'b0, req.a} + {1'b0, bb} + {8'h00, ci};
                c7   = lo7[7];
                rsp.res = full[7:0];
                rsp.c   = full[8];
                rsp.hc  = lo[4];
                rsp.ovf = c7 ^ full[8];
            end
            flag_pkg::op_rlc: begin
                rsp.res = {req.a[6:0], cin};
                rsp.c   = req.a[7];
            end
            flag_pkg::op_rrc: begin
                rsp.res = {cin, req.a[7:1]};
                rsp.c   = req.a[0];
            end
            default: begin
                rsp.res = req.a;
                rsp.c   = cin;
            end
        endcase
        rsp.z = (rsp.res == 8'h00);
    end
endmodule : flag_alu
`default_nettype wire

//--- sys_flags.sv
`default_nettype none
module sys_flags (
    input  wire  logic clk,
    input  wire  logic nrst,
    input  wire  logic wdt_clear,
    input  wire  logic sleep,
    input  wire  logic wdt_timeout,
    output logic       to_flag,
    output logic       pd_flag
);
    typedef struct packed {
        logic to;
        logic pd;
    } sys_state_type;

    sys_state_type state_ff;
    sys_state_type nxt_state;

    // ----------------------------------------
    // system flags
    // ----------------------------------------
    // time-out set wins over a same-cycle clear so the event is never lost
    always_comb begin
        nxt_state = state_ff;
        if (wdt_clear) begin
            nxt_state.pd = 1'b0;
        end else if (sleep) begin
            nxt_state.pd = 1'b1;
        end
        if (wdt_clear || sleep) begin
            nxt_state.to = 1'b0;
        end
        if (wdt_timeout) begin
            nxt_state.to = 1'b1;
        end
    end

    // power-up clears both
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign to_flag = state_ff.to;
    assign pd_flag = state_ff.pd;
endmodule : sys_flags
`default_nettype wire

//--- cpu_status_flag_props.sv
`default_nettype none
// ------------------------------------------------------------
// status flag checker
// ------------------------------------------------------------
module cpu_status_flag_props (
    input wire logic                  clk,
    input wire logic                  nrst,
    input wire logic                  instr_done,
    input wire flag_pkg::alu_req_type alu_req,
    input wire logic                  wr_en,
    input wire logic [7:0]            wr_data,
    input wire logic                  watchdog_clear_instr,
    input wire logic                  sleep_instr,
    input wire logic                  wdt_timeout,
    input wire logic [7:0]            cpu_status_flags,
    input wire logic [7:0]            alu_result
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // an alu op is taken unless a software store wins the same edge
    sequence s_alu;
        instr_done && alu_req.op != flag_pkg::op_none && !wr_en;
    endsequence
    sequence s_sub;
        s_alu ##0 alu_req.op == flag_pkg::op_sub;
    endsequence
    sequence s_sbc;
        s_alu ##0 alu_req.op == flag_pkg::op_sbc;
    endsequence
    a_sc_xor: assert property (s_alu |=> cpu_status_flags[7] == (cpu_status_flags[3] ^ alu_result[7]))
        else $error("sc is not ov xor msb");
    a_cz_plain: assert property (s_sub |=> cpu_status_flags[6] == cpu_status_flags[2])
        else $error("cz differs from z after sub");
    a_cz_chain: assert property (s_sbc |=> cpu_status_flags[6] == ($past(cpu_status_flags[6]) && cpu_status_flags[2]))
        else $error("cz chain wrong after sbc");
    a_cz_hold: assert property (!wr_en && !(instr_done && alu_req.op inside {flag_pkg::op_sub, flag_pkg::op_sbc})
        |=> $stable(cpu_status_flags[6]))
        else $error("cz changed");
    a_zero_res: assert property (s_alu |=> cpu_status_flags[2] == (alu_result == 8'h00))
        else $error("z does not match result");
    a_sys_stable: assert property (!watchdog_clear_instr && !sleep_instr && !wdt_timeout
        |=> $stable(cpu_status_flags[5:4]))
        else $error("system flags moved");
    a_sleep_sets: assert property (sleep_instr && !watchdog_clear_instr && !wdt_timeout |=> cpu_status_flags[5:4] == 2'h1)
        else $error("sleep flags wrong");
    a_clear_both: assert property (watchdog_clear_instr && !wdt_timeout |=> cpu_status_flags[5:4] == 2'h0)
        else $error("watchdog clear flags wrong");
    a_to_set: assert property (wdt_timeout |=> cpu_status_flags[5])
        else $error("timeout flag not set");
    a_wr_bits: assert property (wr_en |=> (cpu_status_flags & 8'hCF) == ($past(wr_data) & 8'hCF))
        else $error("written bits wrong");
    a_arith_hold: assert property (!wr_en && !instr_done |=> $stable(cpu_status_flags & 8'hCF))
        else $error("arithmetic flags moved");
endmodule : cpu_status_flag_props
`default_nettype wire

//--- test_cpu_status_flag_logic.sv
`default_nettype none
module test_cpu_status_flag_logic;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk = 1'b0;
    logic                  nrst = 1'b0;
    logic                  instr_done = 1'b0;
    flag_pkg::alu_req_type alu_req = '0;
    logic                  wr_en = 1'b0;
    logic [7:0]            wr_data = 8'h00;
    logic                  watchdog_clear_instr = 1'b0;
    logic                  sleep_instr = 1'b0;
    logic                  wdt_timeout = 1'b0;
    logic [7:0]            cpu_status_flags;
    logic [7:0]            alu_result;
    logic [7:0]            exp_flags = 8'h00;
    int                    errors = 0;
    int                    checks = 0;
    // ------------------------------------------------------------
    // clock, design, helpers
    // ------------------------------------------------------------
    always #5 clk = ~clk;
    cpu_status_flag_logic cpu_status_flag_logic_i (.clk(clk), .nrst(nrst), .instr_done(instr_done),
        .alu_req(alu_req), .wr_en(wr_en), .wr_data(wr_data), .watchdog_clear_instr(watchdog_clear_instr),
        .sleep_instr(sleep_instr), .wdt_timeout(wdt_timeout), .cpu_status_flags(cpu_status_flags),
        .alu_result(alu_result));
    task automatic final_report;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    task automatic cmp(input logic [7:0] got, input logic [7:0] want);
        checks++;
        if (got !== want) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : cmp
    // reference model: subtract is a + ~b + carry-in, carry means no borrow
    task automatic alu(input flag_pkg::alu_op_type op, input logic [7:0] a, input logic [7:0] b);
        logic [7:0] bb;
        logic [7:0] r;
        logic       ci;
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] l;
        bb = (op inside {flag_pkg::op_sub, flag_pkg::op_sbc}) ? ~b : b;
        ci = (op == flag_pkg::op_sub) || (op inside {flag_pkg::op_addc, flag_pkg::op_sbc} && exp_flags[0]);
        s = {1'b0, a} + {1'b0, bb} + 9'(ci);
        h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + 5'(ci);
        l = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + 8'(ci);
        r = (op == flag_pkg::op_logic) ? a : s[7:0];
        @(posedge clk);
        instr_done <= 1'b1;
        alu_req <= '{op, a, b};
        @(posedge clk);
        instr_done <= 1'b0;
        #1;
        if (op inside {[flag_pkg::op_add : flag_pkg::op_sbc]}) exp_flags[3:0] = {l[7] ^ s[8], 1'b0, h[4], s[8]};
        if (op == flag_pkg::op_rlc) {exp_flags[0], r} = {a, exp_flags[0]};
        if (op == flag_pkg::op_rrc) {r, exp_flags[0]} = {exp_flags[0], a};
        if (op != flag_pkg::op_none) exp_flags[2] = (r == 8'h00);
        if (op != flag_pkg::op_none) exp_flags[7] = exp_flags[3] ^ r[7];
        if (op == flag_pkg::op_sub) exp_flags[6] = exp_flags[2];
        if (op == flag_pkg::op_sbc) exp_flags[6] = exp_flags[6] & exp_flags[2];
        if (op != flag_pkg::op_none) cmp(alu_result, r);
        cmp(cpu_status_flags, exp_flags);
    endtask : alu
    // one cycle of system events and an optional store; clear beats sleep, timeout beats clear
    task automatic sys(input logic wd, input logic sl, input logic wt, input logic we, input logic [7:0] d);
        @(posedge clk);
        {watchdog_clear_instr, sleep_instr, wdt_timeout, wr_en, wr_data} <= {wd, sl, wt, we, d};
        @(posedge clk);
        {watchdog_clear_instr, sleep_instr, wdt_timeout, wr_en} <= 4'h0;
        #1;
        if (we) exp_flags = (d & ~flag_pkg::SYS_BITS_MASK) | (exp_flags & flag_pkg::SYS_BITS_MASK);
        if (sl) exp_flags[5:4] = 2'h1;
        if (wd) exp_flags[5:4] = 2'h0;
        if (wt) exp_flags[5] = 1'b1;
        cmp(cpu_status_flags, exp_flags);
    endtask : sys
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_add;
        alu(flag_pkg::op_add, 8'hFF, 8'h01);
        alu(flag_pkg::op_addc, 8'h00, 8'h00);
        alu(flag_pkg::op_add, 8'h7F, 8'h01);
        alu(flag_pkg::op_none, 8'h00, 8'h00);
        $display("t_add done");
    endtask : t_add
    task automatic t_sub;
        alu(flag_pkg::op_sub, 8'h05, 8'h05);
        alu(flag_pkg::op_sbc, 8'h00, 8'h00);
        alu(flag_pkg::op_sbc, 8'h01, 8'h00);
        alu(flag_pkg::op_sbc, 8'h00, 8'h00);
        alu(flag_pkg::op_sub, 8'h03, 8'h05);
        alu(flag_pkg::op_sub, 8'h80, 8'h01);
        $display("t_sub done");
    endtask : t_sub
    task automatic t_rot;
        alu(flag_pkg::op_rlc, 8'h81, 8'h00);
        alu(flag_pkg::op_rrc, 8'h01, 8'h00);
        alu(flag_pkg::op_logic, 8'h00, 8'h5A);
        $display("t_rot done");
    endtask : t_rot
    task automatic t_sys;
        sys(1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
        sys(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
        sys(1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
        sys(1'b1, 1'b1, 1'b0, 1'b0, 8'h00);
        sys(1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
        sys(1'b0, 1'b0, 1'b0, 1'b1, 8'hFF);
        sys(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
        $display("t_sys done");
    endtask : t_sys
    // main sequence: two reset cycles, then the scenarios
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        #1;
        cmp(cpu_status_flags, flag_pkg::STATUS_RESET);
        t_add();
        t_sub();
        t_rot();
        t_sys();
        final_report();
    end
    // watchdog: the scenarios need well under a thousand cycles
    initial begin
        #20000;
        errors++;
        final_report();
    end
endmodule : test_cpu_status_flag_logic
bind cpu_status_flag_logic cpu_status_flag_props cpu_status_flag_props_i (.clk(clk), .nrst(nrst),
    .instr_done(instr_done), .alu_req(alu_req), .wr_en(wr_en), .wr_data(wr_data),
    .watchdog_clear_instr(watchdog_clear_instr), .sleep_instr(sleep_instr), .wdt_timeout(wdt_timeout),
    .cpu_status_flags(cpu_status_flags), .alu_result(alu_result));
`default_nettype wire
